// *** common/rtcp_pkg.sv ***
package rtcp_pkg;

    // Register port geometry and register indices.
    localparam int          ADDR_W    = 4;
    localparam int          DATA_W    = 8;
    localparam logic [3:0]  SEC_IDX   = 4'h0;
    localparam logic [3:0]  CTRL1_IDX = 4'hE;
    localparam logic [3:0]  CTRL2_IDX = 4'hF;

    // Control register 1 field positions.
    localparam int C1_WEEK_EN = 7;
    localparam int C1_DAY_EN  = 6;
    localparam int C1_CLKDIS_B = 4;
    localparam int C1_SEL_LSB = 0;
    localparam int SEL_W      = 3;

    // Control register 2 field positions.
    localparam int C2_PON     = 4;
    localparam int C2_CLKDIS_A = 3;
    localparam int C2_PER_FLAG = 2;
    localparam int C2_WEEK_FLAG = 1;
    localparam int C2_DAY_FLAG = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic       PON_RESET  = 1'b1;

    // Period select codes.
    typedef enum logic [2:0] {
        SEL_OFF     = 3'h0,
        SEL_LOW     = 3'h1,
        SEL_PULSE2  = 3'h2,
        SEL_PULSE1  = 3'h3,
        SEL_SECOND  = 3'h4,
        SEL_MINUTE  = 3'h5,
        SEL_HOUR    = 3'h6,
        SEL_MONTH   = 3'h7
    } rtcp_sel_t;

    // Oscillator divider.
    localparam longint      OSC_HZ      = 32768;
    localparam int          PRESC_W     = 16;
    localparam logic [15:0] TICKS_LAST  = 16'h7FFF;
    localparam logic [15:0] TICKS_HALF  = 16'h4000;
    localparam int          HZ2_BIT     = 13;

    // Second increment lag behind the pulse falling edge.
    localparam longint      INC_DELAY_US = 92;
    localparam logic [15:0] INC_DELAY_TICKS =
        16'((INC_DELAY_US * OSC_HZ) / 64'h0F4240);

    // Oscillation adjustment: maximum shift and period.
    localparam longint      ADJ_MAX_NS    = 3784000;
    localparam logic signed [7:0] ADJ_MAX_TICKS =
        8'((ADJ_MAX_NS * OSC_HZ) / 64'h3B9ACA00);
    localparam logic [4:0]  ADJ_PERIOD_S  = 5'h14;

endpackage

// *** rtl/rtcp_sync.sv ***
`timescale 1ns/100ps
module rtcp_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // The first stage feeds only the second.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** rtl/rtcp_prescaler.sv ***
`timescale 1ns/100ps
module rtcp_prescaler (
    // Clock and reset.
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Oscillator tick and restart.
    input  wire logic                          tick,
    input  wire logic                          restart,
    // Oscillation adjustment.
    input  wire logic                          adj_en,
    input  wire logic signed [7:0]             adj_offset,
    // Divider state.
    output logic        [rtcp_pkg::PRESC_W-1:0] count,
    output logic        [rtcp_pkg::PRESC_W-1:0] half_point,
    output logic                               wrap
);
    import rtcp_pkg::*;

    function automatic logic signed [7:0] clamp(
        input logic signed [7:0] a
    );
        if (a > ADJ_MAX_TICKS) begin
            clamp = ADJ_MAX_TICKS;
        end else if (a < -ADJ_MAX_TICKS) begin
            clamp = -ADJ_MAX_TICKS;
        end else begin
            clamp = a;
        end
    endfunction

    logic [4:0] sec_mod;
    wire        adj_now  = adj_en && (sec_mod == '0);
    wire  [15:0] adj_ext = adj_now ? 16'(signed'(clamp(adj_offset)))
                                   : '0;
    wire  [15:0] terminal = TICKS_LAST + adj_ext;
    wire        at_end   = tick && (count == terminal);

    assign half_point = TICKS_HALF + adj_ext;
    assign wrap       = at_end;

    // A restart clears every stage below the second.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count   <= '0;
            sec_mod <= '0;
        end else if (restart) begin
            count   <= '0;
            sec_mod <= '0;
        end else if (at_end) begin
            count   <= '0;
            sec_mod <= (sec_mod == ADJ_PERIOD_S - 5'h01) ? '0
                                                         : sec_mod + 5'h01;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    chk_adj_bounded: assert property (@(posedge core_clk) disable iff (!rst_n)
        (half_point <= TICKS_HALF + 16'(ADJ_MAX_TICKS)) &&
        (half_point >= TICKS_HALF - 16'(ADJ_MAX_TICKS)))
        else $error("Adjusted half period out of range.");
endmodule

// *** rtl/rtcp_periodic_top.sv ***
// How it works
// - Select 000 output high, 001 fixed low.
// - Pulse codes give 2 Hz, 1 Hz square.
// - Level mode holds low until flag cleared.
// - Level codes fire each second, minute, hour, month.
// - Second increments 92 us after pulse falling.
// - Seconds write restarts divider, pulse output low.
// - Level falling edge matches second increment.
// - Adjustment shifts period every 20 seconds, bounded.
// - Clock out needs control pin and one enable.
// - Clock gating follows control pin without glitches.
// - Shared interrupt pin low while either source asserted.
// - Flag write one ignored, zero clears.
`timescale 1ns/100ps
module rtcp_periodic_top (
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    // Register port.
    input  wire logic [rtcp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rtcp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [rtcp_pkg::DATA_W-1:0] reg_rdata,
    // Oscillator and clock output pins.
    input  wire logic                        osc_32k_pin,
    input  wire logic                        clkout_control_pin,
    output logic                             slow_clock_output,
    // Calendar boundaries that the next second reaches.
    input  wire logic                        cal_minute_start,
    input  wire logic                        cal_hour_start,
    input  wire logic                        cal_month_start,
    output logic                             sec_inc,
    // Alarm matches and oscillation adjustment.
    input  wire logic                        week_alarm_match,
    input  wire logic                        day_alarm_match,
    input  wire logic                        adj_enable,
    input  wire logic signed [7:0]           adj_offset,
    // Open-drain interrupt pins.
    input  wire logic                        irq_out_a_n_i,
    output logic                             irq_out_a_n_o,
    output logic                             irq_out_a_n_oe,
    input  wire logic                        irq_out_b_n_i,
    output logic                             irq_out_b_n_o,
    output logic                             irq_out_b_n_oe
);
    import rtcp_pkg::*;

    function automatic logic is_level(input logic [2:0] s);
        is_level = s[2];
    endfunction

    function automatic logic is_pulse(input logic [2:0] s);
        is_pulse = (s == SEL_PULSE2) || (s == SEL_PULSE1);
    endfunction

    // Reset release.
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // Pin synchronisation.
    logic [1:0] pins_s;
    rtcp_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in ({clkout_control_pin, osc_32k_pin}),
        .sync_out (pins_s)
    );
    wire osc_s  = pins_s[0];
    wire clkout_control_pin_s = pins_s[1];

    logic osc_d;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_d <= 1'b0;
        end else begin
            osc_d <= osc_s;
        end
    end
    wire osc_tick = osc_s && !osc_d;

    // Control state.
    logic       week_alarm_enable;
    logic       day_alarm_enable;
    logic       clkout_disable_a;
    logic       clkout_disable_b;
    logic [2:0] period_select;
    logic       pon;
    logic       periodic_flag;
    logic       week_alarm_flag;
    logic       day_alarm_flag;

    wire period_select_bit2 = period_select[2];
    wire period_select_bit1 = period_select[1];
    wire period_select_bit0 = period_select[0];

    wire wr_sec   = reg_wr && (reg_addr == SEC_IDX);
    wire wr_c1    = reg_wr && (reg_addr == CTRL1_IDX);
    wire wr_c2    = reg_wr && (reg_addr == CTRL2_IDX);
    wire clr_per  = wr_c2 && !reg_wdata[C2_PER_FLAG];
    wire clr_week = wr_c2 && !reg_wdata[C2_WEEK_FLAG];
    wire clr_day  = wr_c2 && !reg_wdata[C2_DAY_FLAG];
    wire clr_pon  = wr_c2 && !reg_wdata[C2_PON];

    // Divider.
    logic [15:0] presc_count;
    logic [15:0] half_point;
    logic        presc_wrap;
    rtcp_prescaler u_presc (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .tick       (osc_tick),
        .restart    (wr_sec),
        .adj_en     (adj_enable),
        .adj_offset (adj_offset),
        .count      (presc_count),
        .half_point (half_point),
        .wrap       (presc_wrap)
    );

    // Second increment timing.
    wire inc_pulse = osc_tick &&
                     (presc_count == INC_DELAY_TICKS - 16'h0001);
    wire next_sec_inc = is_pulse(period_select) ? inc_pulse
                                                : presc_wrap;

    // Level mode period events.
    wire lvl_hit =
        (period_select == SEL_SECOND) ||
        (period_select == SEL_MINUTE && cal_minute_start) ||
        (period_select == SEL_HOUR   && cal_hour_start)   ||
        (period_select == SEL_MONTH  && cal_month_start);
    wire per_set  = presc_wrap && lvl_hit;
    wire week_set = week_alarm_match && week_alarm_enable;
    wire day_set  = day_alarm_match && day_alarm_enable;

    // Control registers; a set beats a clear in the same cycle.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {week_alarm_enable, day_alarm_enable} <= 2'h0;
            {clkout_disable_a, clkout_disable_b}  <= 2'h0;
            period_select   <= SEL_OFF;
            pon             <= PON_RESET;
            periodic_flag   <= 1'b0;
            week_alarm_flag <= 1'b0;
            day_alarm_flag  <= 1'b0;
        end else if (pon) begin
            {week_alarm_enable, day_alarm_enable} <= 2'h0;
            {clkout_disable_a, clkout_disable_b}  <= 2'h0;
            period_select   <= SEL_OFF;
            pon             <= !clr_pon;
            periodic_flag   <= 1'b0;
            week_alarm_flag <= 1'b0;
            day_alarm_flag  <= 1'b0;
        end else begin
            if (wr_c1) begin
                week_alarm_enable <= reg_wdata[C1_WEEK_EN];
                day_alarm_enable  <= reg_wdata[C1_DAY_EN];
                clkout_disable_b  <= reg_wdata[C1_CLKDIS_B];
                period_select     <= reg_wdata[C1_SEL_LSB +: SEL_W];
            end
            if (wr_c2) begin
                clkout_disable_a <= reg_wdata[C2_CLKDIS_A];
            end
            periodic_flag   <= per_set  || (periodic_flag && !clr_per);
            week_alarm_flag <= week_set || (week_alarm_flag && !clr_week);
            day_alarm_flag  <= day_set  || (day_alarm_flag && !clr_day);
        end
    end

    // Periodic output level.
    wire pulse_low2 = !presc_count[HZ2_BIT];
    wire pulse_low1 = presc_count < half_point;
    logic periodic_low;
    logic next_periodic_low;
    always_comb begin
        case (period_select)
            SEL_OFF:    next_periodic_low = 1'b0;
            SEL_LOW:    next_periodic_low = 1'b1;
            SEL_PULSE2: next_periodic_low = pulse_low2;
            SEL_PULSE1: next_periodic_low = pulse_low1;
            default:    next_periodic_low = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            periodic_low <= 1'b0;
            sec_inc      <= 1'b0;
        end else begin
            periodic_low <= next_periodic_low;
            sec_inc      <= next_sec_inc;
        end
    end

    // Shared pin combines periodic and day alarm sources.
    wire per_drive = is_level(period_select) ? periodic_flag
                                             : periodic_low;
    assign irq_out_a_n_o  = 1'b0;
    assign irq_out_a_n_oe = per_drive || day_alarm_flag;
    assign irq_out_b_n_o  = 1'b0;
    assign irq_out_b_n_oe = week_alarm_flag;

    // Clock output gate changes only while the clock is low.
    wire  gate_want = clkout_control_pin_s &&
                      !(clkout_disable_a && clkout_disable_b);
    logic clk_gate;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_gate          <= 1'b0;
            slow_clock_output <= 1'b0;
        end else begin
            if (!osc_s) begin
                clk_gate <= gate_want;
            end
            slow_clock_output <= osc_s && clk_gate;
        end
    end

    // Register read port.
    wire [7:0] ctrl1_rd = {week_alarm_enable, day_alarm_enable, 1'b0,
                           clkout_disable_b, 1'b0, period_select_bit2,
                           period_select_bit1, period_select_bit0};
    wire [7:0] ctrl2_rd = {3'h0, pon, clkout_disable_a, periodic_flag,
                           week_alarm_flag, day_alarm_flag};
    wire [7:0] rd_mux = (reg_addr == CTRL1_IDX) ? ctrl1_rd :
                        (reg_addr == CTRL2_IDX) ? ctrl2_rd : CTRL_RESET;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_off_high: assert property (
        period_select == SEL_OFF && $past(period_select) == SEL_OFF
        |-> !periodic_low) else $error("Off select drove output low.");
    chk_fixed_low: assert property (
        period_select == SEL_LOW && $past(period_select) == SEL_LOW
        |-> periodic_low) else $error("Fixed low select left output high.");
    chk_level_hold: assert property (
        is_level(period_select) && periodic_flag && !clr_per && !pon
        |=> irq_out_a_n_oe) else $error("Level output released early.");
    chk_flag_write_one: assert property (
        day_alarm_flag && wr_c2 && reg_wdata[C2_DAY_FLAG] && !pon
        |=> day_alarm_flag) else $error("Writing one cleared a flag.");
    chk_flag_clear: assert property (
        periodic_flag && clr_per && !per_set
        |=> !periodic_flag) else $error("Writing zero kept the flag.");
    chk_level_edge: assert property (
        $rose(periodic_flag) && is_level($past(period_select))
        |-> sec_inc) else $error("Level edge not on second increment.");
    chk_inc_delay: assert property (
        sec_inc && is_pulse($past(period_select)) && !$past(wr_sec)
        |-> presc_count == INC_DELAY_TICKS)
        else $error("Second increment lag wrong.");
    chk_restart_low: assert property (
        wr_sec && is_pulse(period_select) && $stable(period_select)
        |-> ##2 periodic_low) else $error("Restart did not drive low.");
    chk_gate_off: assert property (
        !clk_gate |=> !slow_clock_output)
        else $error("Clock output ran while gated.");
    chk_shared_pin: assert property (
        day_alarm_flag |-> irq_out_a_n_oe)
        else $error("Day alarm not on shared pin.");
    chk_level_set: assert property (
        per_set && !pon |=> periodic_flag)
        else $error("Level event did not set flag.");

    cov_level_event: cover property (per_set ##1 periodic_flag);
    cov_pulse_restart: cover property (wr_sec && is_pulse(period_select));
    cov_clock_on: cover property ($rose(slow_clock_output));
    cov_both_sources: cover property (periodic_flag && day_alarm_flag);
endmodule

// *** verification/rtcp_host_model.sv ***
`timescale 1ns/100ps
module rtcp_host_model (
    // Clock.
    input  wire logic        core_clk,
    // Open-drain interrupt pins as the block drives them.
    input  wire logic        irq_a_o,
    input  wire logic        irq_a_oe,
    input  wire logic        irq_b_o,
    input  wire logic        irq_b_oe,
    // Clock output and the host's wish to receive it.
    input  wire logic        slow_clk,
    input  wire logic        clk_want,
    input  wire logic        receivers_on,
    output logic             clk_ctrl,
    // Resolved pin levels and received clock edges.
    output logic             irq_a_lvl,
    output logic             irq_b_lvl,
    output logic [15:0]      clk_edges
);
    logic slow_q;

    // Pull-up resistors hold a released pin high.
    assign irq_a_lvl = irq_a_oe ? irq_a_o : 1'h1;
    assign irq_b_lvl = irq_b_oe ? irq_b_o : 1'h1;
    // The clock is only asked for while its receivers have power.
    assign clk_ctrl = clk_want & receivers_on;

    initial begin
        slow_q    = 1'h0;
        clk_edges = 16'h0000;
    end

    // Counts rising edges of the received clock.
    always @(posedge core_clk) begin
        slow_q <= slow_clk;
        if (slow_clk && !slow_q) begin
            clk_edges <= clk_edges + 16'h0001;
        end
    end
endmodule

// *** verification/test_rtcp_periodic_top.sv ***
`timescale 1ns/100ps
module test_rtcp_periodic_top;
    import rtcp_pkg::*;
    logic        core_clk, nrst, reg_wr, reg_rd, osc;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rv;
    logic        clk_ctrl, slow_out, sec_inc, wk, dy, want, pwr;
    logic        a_o, a_oe, b_o, b_oe, a_lvl, b_lvl;
    logic [15:0] edges, e0;
    int          fails, checks, cycles;

    rtcp_periodic_top dut_u (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_32k_pin(osc),
        .clkout_control_pin(clk_ctrl), .slow_clock_output(slow_out),
        .cal_minute_start(1'h0), .cal_hour_start(1'h0),
        .cal_month_start(1'h0), .sec_inc(sec_inc),
        .week_alarm_match(wk), .day_alarm_match(dy),
        .adj_enable(1'h0), .adj_offset(8'sh00),
        .irq_out_a_n_i(a_lvl), .irq_out_a_n_o(a_o), .irq_out_a_n_oe(a_oe),
        .irq_out_b_n_i(b_lvl), .irq_out_b_n_o(b_o), .irq_out_b_n_oe(b_oe));

    rtcp_host_model host_u (
        .core_clk(core_clk), .irq_a_o(a_o), .irq_a_oe(a_oe),
        .irq_b_o(b_o), .irq_b_oe(b_oe), .slow_clk(slow_out),
        .clk_want(want), .receivers_on(pwr), .clk_ctrl(clk_ctrl),
        .irq_a_lvl(a_lvl), .irq_b_lvl(b_lvl), .clk_edges(edges));

    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    // Oscillator stand-in: one tick every two core cycles, off-edge.
    initial begin
        osc = 1'h0;
        #7;
        forever #100 osc = ~osc;
    end

    task automatic end_of_test;
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 95000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic check_val(input string name, input logic [31:0] exp,
                             input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic t_reset;
        rd(CTRL2_IDX, rv);
        check_val("ctrl2_reset", 8'h10, rv);
        wr(CTRL1_IDX, 8'h01);
        rd(CTRL1_IDX, rv);
        check_val("ctrl1_locked", 8'h00, rv);
        check_val("irq_a_off", 1'h1, a_lvl);
        wr(CTRL2_IDX, 8'h00);
        rd(CTRL2_IDX, rv);
        check_val("ctrl2_clear", 8'h00, rv);
        wr(4'h7, 8'hFF);
        rd(4'h7, rv);
        check_val("unmapped", 8'h00, rv);
        rd(CTRL1_IDX, rv);
        check_val("ctrl1_kept", 8'h00, rv);
    endtask

    task automatic t_fixed;
        wr(CTRL1_IDX, 8'h01);
        cyc(2);
        check_val("sel_low", 1'h0, a_lvl);
        wr(CTRL1_IDX, 8'h00);
        cyc(2);
        check_val("sel_off", 1'h1, a_lvl);
    endtask

    task automatic t_alarm;
        wr(CTRL1_IDX, 8'h00);
        wr(CTRL1_IDX, 8'hC0);
        @(posedge core_clk);
        dy <= 1'h1;
        @(posedge core_clk);
        dy <= 1'h0;
        wk <= 1'h1;
        @(posedge core_clk);
        wk <= 1'h0;
        cyc(1);
        check_val("day_pin", 1'h0, a_lvl);
        check_val("week_pin", 1'h0, b_lvl);
        rd(CTRL2_IDX, rv);
        check_val("alarm_flags", 8'h03, rv);
        wr(CTRL1_IDX, 8'hC1);
        wr(CTRL2_IDX, 8'h06);
        cyc(1);
        check_val("shared_pin", 1'h0, a_lvl);
        check_val("week_kept", 1'h0, b_lvl);
        wr(CTRL1_IDX, 8'hC0);
        cyc(1);
        check_val("shared_off", 1'h1, a_lvl);
        wr(CTRL2_IDX, 8'h05);
        cyc(1);
        check_val("week_clear", 1'h1, b_lvl);
        wr(CTRL1_IDX, 8'h00);
    endtask

    task automatic t_clk;
        logic ok;
        logic [15:0] d;
        for (int i = 0; i < 16; i++) begin
            wr(CTRL1_IDX, {3'h0, i[0], 4'h0});
            wr(CTRL2_IDX, {4'h0, i[1], 3'h7});
            @(posedge core_clk);
            want <= i[2];
            pwr  <= i[3];
            cyc(20);
            e0 = edges;
            cyc(30);
            d  = edges - e0;
            if (i[2] && i[3] && !(i[0] && i[1])) begin
                ok = d >= 16'h000E && d <= 16'h0010;
            end else begin
                ok = d == 16'h0000 && slow_out === 1'h0;
            end
            check_val("clk_gate", 1'h1, ok);
        end
    endtask

    task automatic t_pulse;
        int n;
        int first;
        wr(CTRL1_IDX, 8'h02);
        wr(SEC_IDX, 8'h00);
        cyc(2);
        check_val("restart_low", 1'h0, a_lvl);
        n     = 0;
        first = -1;
        while (a_lvl === 1'h0 && n < 20000) begin
            if (sec_inc === 1'h1 && first < 0) begin
                first = n;
            end
            cyc(1);
            n++;
        end
        check_val("inc_lag", 1'h1, first >= 2 && first <= 12);
        check_val("half_2hz", 1'h1, n > 16300 && n < 16450);
    endtask

    task automatic t_level;
        int   n;
        logic prev;
        wr(CTRL1_IDX, 8'h04);
        wr(SEC_IDX, 8'h00);
        n    = 0;
        prev = 1'h0;
        while (sec_inc !== 1'h1 && n < 70000) begin
            prev = a_lvl;
            cyc(1);
            n++;
        end
        check_val("level_period", 1'h1, n > 65400 && n < 65700);
        check_val("level_before", 1'h1, prev);
        check_val("level_fall", 1'h0, a_lvl);
        rd(CTRL2_IDX, rv);
        check_val("per_flag", 1'h1, rv[C2_PER_FLAG]);
        wr(CTRL2_IDX, 8'h07);
        cyc(5);
        check_val("level_hold", 1'h0, a_lvl);
        wr(CTRL2_IDX, 8'h03);
        cyc(1);
        check_val("level_release", 1'h1, a_lvl);
    endtask

    initial begin
        nrst      = 1'h0;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        wk        = 1'h0;
        dy        = 1'h0;
        want      = 1'h0;
        pwr       = 1'h0;
        fails     = 0;
        checks    = 0;
        cycles    = 0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'h1;
        cyc(4);
        t_reset();
        t_fixed();
        t_alarm();
        t_clk();
        t_pulse();
        t_level();
        end_of_test();
    end
endmodule
